// *** pecu_pkg.sv ***
package pecu_pkg;
    localparam logic [11:0] PECU_GRP_CTRL_ADDR = 12'h7D0;
    localparam int PECU_GRP_EN_BIT = 0;
    localparam logic PECU_GRP_EN_RST = 1'b1;
    localparam logic [11:0] PECU_INHIBIT_ADDR = 12'h320;
    localparam logic [11:0] PECU_EVSEL_BASE = 12'h323;
    localparam logic [11:0] PECU_CNT_LO_BASE = 12'hB03;
    localparam logic [11:0] PECU_CNT_HI_BASE = 12'hB83;
    localparam logic [11:0] PECU_CYCLE_LO_ADDR = 12'hB00;
    localparam logic [11:0] PECU_CYCLE_HI_ADDR = 12'hB80;
    localparam logic [11:0] PECU_INSTRET_LO_ADDR = 12'hB02;
    localparam logic [11:0] PECU_INSTRET_HI_ADDR = 12'hB82;
    localparam logic [11:0] PECU_UNUSED_LO_LAST = 12'hB1F;
    localparam logic [11:0] PECU_UNUSED_HI_LAST = 12'hB9F;
    localparam logic [11:0] PECU_UNUSED_SEL_LAST = 12'h33F;
    localparam int PECU_NUM_CNT = 4;
    localparam int PECU_FIRST_CNT = 3;
    localparam int PECU_NUM_EVT = 45;
    localparam logic [5:0] PECU_EVT_MAX = 6'h2C;
    localparam int PECU_INH_CY_BIT = 0;
    localparam int PECU_INH_IR_BIT = 2;
    localparam logic [6:0] PECU_INH_LEGAL = 7'h7D;
    localparam logic [6:0] PECU_INH_RST = 7'h00;
    localparam logic [63:0] PECU_CNT_RST = 64'h0;
    localparam logic [5:0] PECU_SEL_RST = 6'h00;

    typedef logic [PECU_NUM_EVT-1:0][1:0] pecu_evt_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } pecu_csr_req_t;

    function automatic logic pecu_hit(input logic [11:0] addr, input logic [11:0] base,
                                      input int n);
        return addr == (base + 12'(n));
    endfunction
endpackage

// *** pecu_evt_slot.sv ***
`timescale 1ns/1ps
module pecu_evt_slot
    import pecu_pkg::*;
#(
    parameter int IDX = 0
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // register access
    input pecu_csr_req_t req,
    // counting
    input wire logic count_en,
    input pecu_evt_t events,
    // state
    output logic [5:0] sel_out,
    output logic [63:0] cnt_out
);
    typedef struct packed {
        logic [5:0] sel;
        logic [63:0] cnt;
    } pecu_slot_state_t;

    pecu_slot_state_t q, d;
    logic wr_lo, wr_hi, wr_sel;
    logic [1:0] inc;

    assign wr_lo = req.wr && pecu_hit(req.addr, PECU_CNT_LO_BASE, IDX);
    assign wr_hi = req.wr && pecu_hit(req.addr, PECU_CNT_HI_BASE, IDX);
    assign wr_sel = req.wr && pecu_hit(req.addr, PECU_EVSEL_BASE, IDX);

    always_comb begin
        d = q;
        // selector 0 is wired to no event
        inc = (count_en && q.sel != 6'h00) ? events[q.sel] : 2'h0;
        d.cnt = q.cnt + 64'(inc);
        // increment first, then the written half overrides it
        if (wr_lo) begin
            d.cnt[31:0] = req.wdata;
        end
        if (wr_hi) begin
            d.cnt[63:32] = req.wdata;
        end
        if (wr_sel) begin
            d.sel = (req.wdata > 32'(PECU_EVT_MAX)) ? PECU_EVT_MAX : req.wdata[5:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            q <= '{sel: PECU_SEL_RST, cnt: PECU_CNT_RST};
        end else begin
            q <= d;
        end
    end

    assign sel_out = q.sel;
    assign cnt_out = q.cnt;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    chk_sel_clamp_high: assert property (wr_sel && req.wdata > 32'(PECU_EVT_MAX)
        |=> q.sel == PECU_EVT_MAX) else $error("selector not clamped");
    chk_sel_zero_idle: assert property (q.sel == 6'h00 && !wr_lo && !wr_hi
        |=> $stable(q.cnt)) else $error("selector zero counted");
    chk_add_two: assert property (count_en && q.sel != 6'h00
        && events[q.sel] == 2'h2 && !wr_lo && !wr_hi
        |=> q.cnt == $past(q.cnt) + 64'h2) else $error("double event not added");
    chk_write_wins: assert property (wr_lo && !wr_hi
        |=> q.cnt[31:0] == $past(req.wdata)) else $error("low write lost");
    chk_gate_hold: assert property (!count_en && !wr_lo && !wr_hi
        |=> $stable(q.cnt)) else $error("counter moved while gated");

    cov_double_event: cover property (count_en && q.sel != 6'h00 && events[q.sel] == 2'h2);
    cov_carry_high: cover property (count_en && q.cnt[31:0] == 32'hFFFFFFFF && inc != 2'h0);
endmodule

// *** pecu_top.sv ***
`timescale 1ns/1ps
module pecu_top
    import pecu_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // control register access
    input pecu_csr_req_t csr_req,
    output logic [31:0] csr_rdata,
    output logic csr_rvalid,
    // core halt status
    input wire logic power_mgmt_halt_state,
    input wire logic debug_halt_state,
    input wire logic dbg_stopcount,
    // event sources
    input pecu_evt_t events,
    input wire logic [1:0] instr_retired
);
    typedef struct packed {
        logic grp_en;
        logic [6:0] inhibit;
        logic [63:0] cycle;
        logic [63:0] instret;
        logic [31:0] rdata;
        logic rvalid;
    } pecu_top_state_t;

    pecu_top_state_t q, d;
    logic count_ok;
    logic [PECU_NUM_CNT-1:0] slot_en;
    logic [PECU_NUM_CNT-1:0][5:0] sel_w;
    logic [PECU_NUM_CNT-1:0][63:0] cnt_w;
    logic [31:0] rd_mux;

    // pause is not a halt state, so it does not appear here
    assign count_ok = !power_mgmt_halt_state
        && !(debug_halt_state && dbg_stopcount);

    genvar gi;
    generate
        for (gi = 0; gi < PECU_NUM_CNT; gi++) begin : g_slot
            assign slot_en[gi] = count_ok && q.grp_en
                && !q.inhibit[PECU_FIRST_CNT + gi];
            pecu_evt_slot #(.IDX(gi)) u_slot (
                .clock(clock),
                .reset_n(reset_n),
                .req(csr_req),
                .count_en(slot_en[gi]),
                .events(events),
                .sel_out(sel_w[gi]),
                .cnt_out(cnt_w[gi])
            );
        end
    endgenerate

    // counters 7..31 and their selectors have no storage, so they read zero
    always_comb begin
        rd_mux = 32'h0;
        case (csr_req.addr)
            PECU_GRP_CTRL_ADDR: rd_mux = {31'h0, q.grp_en};
            PECU_INHIBIT_ADDR: rd_mux = {25'h0, q.inhibit};
            PECU_CYCLE_LO_ADDR: rd_mux = q.cycle[31:0];
            PECU_CYCLE_HI_ADDR: rd_mux = q.cycle[63:32];
            PECU_INSTRET_LO_ADDR: rd_mux = q.instret[31:0];
            PECU_INSTRET_HI_ADDR: rd_mux = q.instret[63:32];
            default: rd_mux = 32'h0;
        endcase
        for (int i = 0; i < PECU_NUM_CNT; i++) begin
            if (pecu_hit(csr_req.addr, PECU_EVSEL_BASE, i)) begin
                rd_mux = {26'h0, sel_w[i]};
            end
            if (pecu_hit(csr_req.addr, PECU_CNT_LO_BASE, i)) begin
                rd_mux = cnt_w[i][31:0];
            end
            if (pecu_hit(csr_req.addr, PECU_CNT_HI_BASE, i)) begin
                rd_mux = cnt_w[i][63:32];
            end
        end
    end

    always_comb begin
        d = q;
        // the read samples the pre-increment value in this same cycle
        d.rvalid = csr_req.rd;
        d.rdata = csr_req.rd ? rd_mux : q.rdata;
        if (count_ok && !q.inhibit[PECU_INH_CY_BIT]) begin
            d.cycle = q.cycle + 64'h1;
        end
        if (count_ok && !q.inhibit[PECU_INH_IR_BIT]) begin
            d.instret = q.instret + 64'(instr_retired);
        end
        if (csr_req.wr) begin
            case (csr_req.addr)
                PECU_GRP_CTRL_ADDR: d.grp_en = csr_req.wdata[PECU_GRP_EN_BIT];
                PECU_INHIBIT_ADDR: d.inhibit = csr_req.wdata[6:0] & PECU_INH_LEGAL;
                PECU_CYCLE_LO_ADDR: d.cycle[31:0] = csr_req.wdata;
                PECU_CYCLE_HI_ADDR: d.cycle[63:32] = csr_req.wdata;
                PECU_INSTRET_LO_ADDR: d.instret[31:0] = csr_req.wdata;
                PECU_INSTRET_HI_ADDR: d.instret[63:32] = csr_req.wdata;
                default: d.grp_en = q.grp_en;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            q <= '{grp_en: PECU_GRP_EN_RST, inhibit: PECU_INH_RST, cycle: PECU_CNT_RST,
                   instret: PECU_CNT_RST, rdata: 32'h0, rvalid: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign csr_rdata = q.rdata;
    assign csr_rvalid = q.rvalid;

    // true for the counter and selector addresses of counters 7..31, which have no storage behind them
    function automatic logic unused_addr(input logic [11:0] a);
        logic lo_hit;
        logic hi_hit;
        logic sel_hit;
        lo_hit = a > PECU_CNT_LO_BASE + 12'h3 && a <= PECU_UNUSED_LO_LAST;
        hi_hit = a > PECU_CNT_HI_BASE + 12'h3 && a <= PECU_UNUSED_HI_LAST;
        sel_hit = a > PECU_EVSEL_BASE + 12'h3 && a <= PECU_UNUSED_SEL_LAST;
        return lo_hit || hi_hit || sel_hit;
    endfunction

    // either half of one of the free-running counters
    function automatic logic pair_hit(input logic [11:0] a, input logic [11:0] lo,
                                      input logic [11:0] hi);
        return a == lo || a == hi;
    endfunction

    logic cyc_wr;
    logic ir_wr;
    logic [PECU_NUM_CNT-1:0] slot_allowed;
    assign cyc_wr = csr_req.wr
        && pair_hit(csr_req.addr, PECU_CYCLE_LO_ADDR, PECU_CYCLE_HI_ADDR);
    assign ir_wr = csr_req.wr
        && pair_hit(csr_req.addr, PECU_INSTRET_LO_ADDR, PECU_INSTRET_HI_ADDR);
    // a counter may only run when its own inhibit bit is clear
    assign slot_allowed = ~q.inhibit[PECU_FIRST_CNT +: PECU_NUM_CNT];

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    chk_grp_reset_val: assert property (disable iff (1'b0) !reset_n |=> q.grp_en)
        else $error("group enable not set by reset");
    chk_grp_gates_all: assert property (!q.grp_en |-> slot_en == '0)
        else $error("slot counting with group disabled");
    chk_pm_halt_stop: assert property (power_mgmt_halt_state && !cyc_wr
        |=> $stable(q.cycle)) else $error("cycle counted in power halt");
    chk_dbg_stop: assert property (debug_halt_state && dbg_stopcount
        |-> slot_en == '0) else $error("slot counting in stopped debug halt");
    chk_cycle_runs: assert property (count_ok && !q.inhibit[PECU_INH_CY_BIT]
        && !cyc_wr |=> q.cycle == $past(q.cycle) + 64'h1) else $error("cycle counter stalled");
    chk_grp_read_zero: assert property (csr_req.rd && csr_req.addr == PECU_GRP_CTRL_ADDR
        |=> csr_rvalid && csr_rdata[31:1] == 31'h0) else $error("reserved bits nonzero");
    chk_unused_zero: assert property (csr_req.rd
        && csr_req.addr > PECU_CNT_LO_BASE + 12'h3 && csr_req.addr <= PECU_UNUSED_LO_LAST
        |=> csr_rdata == 32'h0) else $error("unused counter not zero");
    chk_read_old: assert property (csr_req.rd && csr_req.addr == PECU_CYCLE_LO_ADDR
        |=> csr_rdata == $past(q.cycle[31:0])) else $error("read not pre-increment");
    chk_grp_write: assert property (csr_req.wr && csr_req.addr == PECU_GRP_CTRL_ADDR
        |=> q.grp_en == $past(csr_req.wdata[PECU_GRP_EN_BIT]))
        else $error("group enable write lost");
    chk_inh_legal: assert property ((q.inhibit & ~PECU_INH_LEGAL) == 7'h00)
        else $error("illegal inhibit bit stored");
    chk_slots_follow: assert property (count_ok && q.grp_en
        |-> slot_en == slot_allowed) else $error("per-counter enable wrong");
    chk_pm_slots_off: assert property (power_mgmt_halt_state |-> slot_en == '0)
        else $error("slot counting in power halt");
    chk_pm_ret_stop: assert property (power_mgmt_halt_state && !ir_wr
        |=> $stable(q.instret)) else $error("retired counted in power halt");
    chk_dbg_cyc_stop: assert property (debug_halt_state && dbg_stopcount && !cyc_wr
        |=> $stable(q.cycle)) else $error("cycle counted in stopped debug halt");
    chk_dbg_runs: assert property (debug_halt_state && !dbg_stopcount
        && !power_mgmt_halt_state && q.grp_en |-> slot_en == slot_allowed)
        else $error("counting stopped in running debug halt");
    chk_ret_adds: assert property (count_ok && !q.inhibit[PECU_INH_IR_BIT] && !ir_wr
        |=> q.instret == $past(q.instret) + 64'($past(instr_retired)))
        else $error("retired counter wrong");
    chk_cyc_inh: assert property (q.inhibit[PECU_INH_CY_BIT] && !cyc_wr
        |=> $stable(q.cycle)) else $error("inhibited cycle counter moved");
    chk_ret_inh: assert property (q.inhibit[PECU_INH_IR_BIT] && !ir_wr
        |=> $stable(q.instret)) else $error("inhibited retired counter moved");
    chk_unused_any: assert property (csr_req.rd && unused_addr(csr_req.addr)
        |=> csr_rdata == 32'h0) else $error("unused register not zero");
    chk_unused_wr: assert property (csr_req.wr && unused_addr(csr_req.addr)
        |=> sel_w == $past(sel_w)) else $error("unused write changed a selector");
    chk_rvalid_once: assert property (csr_req.rd |=> csr_rvalid)
        else $error("read not answered");
    chk_rvalid_idle: assert property (!csr_req.rd |=> !csr_rvalid)
        else $error("answer without read");
    chk_rdata_hold: assert property (!csr_req.rd |=> $stable(csr_rdata))
        else $error("read data moved without read");

    cov_pm_halt: cover property (power_mgmt_halt_state ##1 !power_mgmt_halt_state);
    cov_grp_off: cover property (q.grp_en ##1 !q.grp_en);
    cov_read_cnt: cover property (csr_req.rd && csr_req.addr == PECU_CNT_LO_BASE);
endmodule

// *** pecu_core_model.sv ***
`timescale 1ns/1ps
module pecu_core_model
    import pecu_pkg::*;
(
    // event request from bench
    input wire logic [5:0] num,
    input wire logic [1:0] amt,
    // pipeline event outputs
    output pecu_evt_t events,
    output logic [1:0] instr_retired
);
    // a pipeline never reports more than two of one event per cycle
    always_comb begin
        events = '0;
        if (num < 6'(PECU_NUM_EVT)) begin
            events[num] = (amt > 2'h2) ? 2'h2 : amt;
        end
        instr_retired = (amt > 2'h2) ? 2'h2 : amt;
    end
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import pecu_pkg::*;
    logic clock = 0;
    logic reset_n = 0;
    logic pm_halt = 0;
    logic dbg_halt = 0;
    logic stopcnt = 0;
    pecu_csr_req_t req = '0;
    logic [31:0] rdata;
    logic [31:0] got;
    logic [31:0] base;
    logic rvalid;
    logic [5:0] num = '0;
    logic [1:0] amt = '0;
    pecu_evt_t events;
    logic [1:0] retired;
    int n_errors = 0;
    int n_checks = 0;
    always #4 clock = ~clock;
    pecu_core_model core (.num(num), .amt(amt), .events(events), .instr_retired(retired));
    pecu_top dut (.clock(clock), .reset_n(reset_n), .csr_req(req), .csr_rdata(rdata),
        .csr_rvalid(rvalid), .power_mgmt_halt_state(pm_halt),
        .debug_halt_state(dbg_halt), .dbg_stopcount(stopcnt), .events(events),
        .instr_retired(retired));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd(input logic [11:0] a);
        int k;
        k = 0;
        @(negedge clock);
        req.rd = 1'b1;
        req.addr = a;
        do begin
            @(posedge clock);
            #1;
            k++;
        end while (rvalid !== 1'b1 && k < 4);
        got = rdata;
        if (rvalid !== 1'b1) begin
            chk("read handshake", 32'h1, 32'h0);
            end_sim();
        end
        @(negedge clock);
        req.rd = 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge clock);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge clock);
        req.wr = 1'b0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
        rd(a);
        chk(what, exp, got);
    endtask
    // hold one event at a fixed count for n rising edges
    task automatic run(input logic [5:0] e, input logic [1:0] c, input int n);
        @(negedge clock);
        num = e;
        amt = c;
        repeat (n) @(negedge clock);
        amt = 2'h0;
        num = 6'h00;
    endtask
    initial begin
        repeat (2000) @(posedge clock);
        n_errors++;
        $display("MISMATCH run time expected done seen hang");
        end_sim();
    end
    initial begin
        repeat (3) @(negedge clock);
        reset_n = 1'b1;
        rchk(PECU_GRP_CTRL_ADDR, 32'h1, "group reset");
        rchk(PECU_INHIBIT_ADDR, 32'h0, "inhibit reset");
        for (int i = 0; i < 4; i++) begin
            rchk(PECU_EVSEL_BASE + 12'(i), 32'h0, "selector reset");
            rchk(PECU_CNT_LO_BASE + 12'(i), 32'h0, "counter reset");
        end
        $display("test reset done");
        wr(PECU_GRP_CTRL_ADDR, 32'hFFFFFFFF);
        rchk(PECU_GRP_CTRL_ADDR, 32'h1, "group legal");
        wr(PECU_GRP_CTRL_ADDR, 32'hFFFFFFFE);
        rchk(PECU_GRP_CTRL_ADDR, 32'h0, "group off");
        wr(PECU_INHIBIT_ADDR, 32'hFFFFFFFF);
        rchk(PECU_INHIBIT_ADDR, 32'h7D, "inhibit legal");
        wr(PECU_INHIBIT_ADDR, 32'h0);
        wr(PECU_EVSEL_BASE, 32'h3F);
        rchk(PECU_EVSEL_BASE, 32'h2C, "selector clamp");
        wr(PECU_UNUSED_SEL_LAST, 32'h5);
        rchk(PECU_UNUSED_SEL_LAST, 32'h0, "unused selector");
        wr(PECU_UNUSED_HI_LAST, 32'h5);
        rchk(PECU_UNUSED_HI_LAST, 32'h0, "unused counter");
        wr(PECU_UNUSED_LO_LAST, 32'h5);
        rchk(PECU_UNUSED_LO_LAST, 32'h0, "unused counter low");
        rchk(PECU_EVSEL_BASE + 12'h4, 32'h0, "selector seven");
        $display("test registers done");
        // selectors change with the group stopped so set-up traffic is not counted
        wr(PECU_EVSEL_BASE, 32'h5);
        wr(PECU_EVSEL_BASE + 12'h2, 32'h7);
        wr(PECU_EVSEL_BASE + 12'h3, 32'h2C);
        wr(PECU_GRP_CTRL_ADDR, 32'h1);
        run(6'h05, 2'h2, 3);
        run(6'h07, 2'h1, 4);
        run(6'h2C, 2'h2, 1);
        rchk(PECU_CNT_LO_BASE, 32'h6, "double events");
        rchk(PECU_CNT_LO_BASE + 12'h1, 32'h0, "selector zero");
        rchk(PECU_CNT_LO_BASE + 12'h2, 32'h4, "own selector");
        rchk(PECU_CNT_LO_BASE + 12'h3, 32'h2, "top event");
        wr(PECU_INHIBIT_ADDR, 32'h08);
        run(6'h05, 2'h2, 2);
        rchk(PECU_CNT_LO_BASE, 32'h6, "inhibited");
        wr(PECU_INHIBIT_ADDR, 32'h0);
        wr(PECU_GRP_CTRL_ADDR, 32'h0);
        run(6'h07, 2'h1, 3);
        rchk(PECU_CNT_LO_BASE + 12'h2, 32'h4, "group stopped");
        wr(PECU_GRP_CTRL_ADDR, 32'h1);
        $display("test counting done");
        pm_halt = 1'b1;
        rd(PECU_CYCLE_LO_ADDR);
        base = got;
        run(6'h07, 2'h1, 3);
        rchk(PECU_CYCLE_LO_ADDR, base, "cycles in halt");
        rchk(PECU_CNT_LO_BASE + 12'h2, 32'h4, "events in halt");
        pm_halt = 1'b0;
        dbg_halt = 1'b1;
        stopcnt = 1'b1;
        run(6'h07, 2'h1, 3);
        rchk(PECU_CNT_LO_BASE + 12'h2, 32'h4, "debug stopped");
        stopcnt = 1'b0;
        run(6'h07, 2'h1, 3);
        rchk(PECU_CNT_LO_BASE + 12'h2, 32'h7, "debug running");
        dbg_halt = 1'b0;
        $display("test halt done");
        wr(PECU_INHIBIT_ADDR, 32'h01);
        wr(PECU_CYCLE_LO_ADDR, 32'h0);
        rchk(PECU_CYCLE_LO_ADDR, 32'h0, "cycle inhibited");
        wr(PECU_INHIBIT_ADDR, 32'h0);
        wr(PECU_CYCLE_LO_ADDR, 32'h0);
        rchk(PECU_CYCLE_LO_ADDR, 32'h1, "cycle running");
        wr(PECU_INSTRET_LO_ADDR, 32'h0);
        run(6'h00, 2'h2, 3);
        rchk(PECU_INSTRET_LO_ADDR, 32'h6, "retired count");
        $display("test free counters done");
        wr(PECU_GRP_CTRL_ADDR, 32'h0);
        wr(PECU_CNT_LO_BASE, 32'hFFFFFFFF);
        wr(PECU_CNT_HI_BASE, 32'h0);
        wr(PECU_GRP_CTRL_ADDR, 32'h1);
        run(6'h05, 2'h1, 1);
        rchk(PECU_CNT_HI_BASE, 32'h1, "carry high");
        rchk(PECU_CNT_LO_BASE, 32'h0, "carry low");
        $display("test carry done");
        wr(PECU_GRP_CTRL_ADDR, 32'h0);
        @(negedge clock);
        reset_n = 1'b0;
        repeat (2) @(negedge clock);
        reset_n = 1'b1;
        rchk(PECU_GRP_CTRL_ADDR, 32'h1, "group after reset");
        rchk(PECU_CNT_HI_BASE, 32'h0, "counter after reset");
        $display("test second reset done");
        end_sim();
    end
endmodule
